/* hw/fls_defines.svh */
/*
 * Constants of the flash status and write-enable bank: opcodes, status bit
 * positions, reset value, address map slices, discovery table and default
 * internal cycle lengths. Assumes inclusion by bare name from design files.
 */
`ifndef FLS_DEFINES_SVH
`define FLS_DEFINES_SVH

// Instruction opcodes
`define FLS_OP_WEN_C       8'h06
`define FLS_OP_WDIS_C      8'h04
`define FLS_OP_SRD_C       8'h05
`define FLS_OP_SFDP_C      8'h5A
`define FLS_OP_SWR_C       8'h01
`define FLS_OP_FWR_C       8'h42
`define FLS_OP_PROG_C      8'h02
`define FLS_OP_QPROG_A_C   8'h32
`define FLS_OP_QPROG_B_C   8'h38
`define FLS_OP_IR_PROG_C   8'h62
`define FLS_OP_SECT_A_C    8'hD7
`define FLS_OP_SECT_B_C    8'h20
`define FLS_OP_HALF_C      8'h52
`define FLS_OP_BLOCK_C     8'hD8
`define FLS_OP_CHIP_A_C    8'hC7
`define FLS_OP_CHIP_B_C    8'h60
`define FLS_OP_IR_ERASE_C  8'h64

// Status register layout
`define FLS_SR_SWD_BIT     7
`define FLS_SR_QUAD_BIT    6
`define FLS_SR_BP_HI       5
`define FLS_SR_BP_LO       2
`define FLS_SR_LATCH_BIT   1
`define FLS_SR_BUSY_BIT    0
`define FLS_SR_RESET       8'h00

// Address map: 8 Mbyte, 4K sectors, 32K and 64K blocks
`define FLS_ADDR_W         23
`define FLS_ADDR_MAX       23'h7F_FFFF
`define FLS_SECTOR_LSB     12
`define FLS_HALF_LSB       15
`define FLS_BLOCK_LSB      16
`define FLS_BLOCK_COUNT    8'h80

// Discovery database
`define FLS_SFDP_SIG       32'h5044_4653
`define FLS_SFDP_ID        16'hFF00
`define FLS_SFDP_BYTES     5'h10

// Default internal cycle lengths in core_clk cycles
`define FLS_T_SWR_CYC      24'h00_0010
`define FLS_T_PROG_CYC     24'h00_0020
`define FLS_T_SER_CYC      24'h00_0040
`define FLS_T_BER_CYC      24'h00_0080
`define FLS_T_CER_CYC      24'h00_0100
`define FLS_CNT_W          24

`endif

/* hw/fls_pkg.sv */
/*
 * Types shared by the flash status bank and its host model, checker and bench.
 * Assumes fls_defines.svh is on the include path.
 */
`include "fls_defines.svh"

package fls_pkg;

  // Decoded instruction handed over by the serial front end
  typedef struct packed {
    logic                      valid;
    logic [7:0]                opcode;
    logic [`FLS_ADDR_W-1:0]    addr;
    logic [7:0]                wdata;
  } fls_instr_t;

  typedef enum logic [2:0] {
    FLS_K_PROG,
    FLS_K_IR_PROG,
    FLS_K_SECTOR,
    FLS_K_HALF,
    FLS_K_BLOCK,
    FLS_K_CHIP,
    FLS_K_IR_ERASE
  } fls_kind_t;

  // Sector and block numbers of an address
  typedef struct packed {
    logic [10:0] sector;
    logic [7:0]  half_block;
    logic [6:0]  block;
  } fls_map_t;

  // Array operation launched toward the array controller
  typedef struct packed {
    logic                   valid;
    fls_kind_t              kind;
    logic [`FLS_ADDR_W-1:0] addr;
    fls_map_t               map;
  } fls_op_t;

  typedef enum logic {
    FLS_READY,
    FLS_CYCLE
  } fls_state_t;

  typedef enum logic [1:0] {
    FLS_RD_NONE,
    FLS_RD_STATUS,
    FLS_RD_SFDP
  } fls_rd_src_t;

endpackage

/* hw/fls_cycle_timer.sv */
/*
 * Down counter that times one internal write, program or erase cycle.
 * Assumes start only while not running; len of zero is treated as one.
 */
`include "fls_defines.svh"

module fls_cycle_timer #(
  parameter int CNT_W = `FLS_CNT_W
) (
  input  wire logic             core_clk,
  input  wire logic             rstn,
  input  wire logic             start,
  input  wire logic [CNT_W-1:0] len,
  output logic                  done,
  output logic                  running
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             run_q;
  logic             run_d;
  logic             done_q;
  logic             done_d;

  // Load on start, count down, pulse done after the last count
  always_comb begin
    cnt_d  = cnt_q;
    run_d  = run_q;
    done_d = 1'b0;
    if (start) begin
      cnt_d = (len == '0) ? CNT_W'(1) : len;
      run_d = 1'b1;
    end else if (run_q) begin
      if (cnt_q <= CNT_W'(1)) begin
        run_d  = 1'b0;
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q  <= '0;
      run_q  <= 1'b0;
      done_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      run_q  <= run_d;
      done_q <= done_d;
    end
  end

  assign done    = done_q;
  assign running = run_q;

endmodule // fls_cycle_timer

/* hw/fls_status_bank.sv */
/*
 * Status register and write-enable gating of the serial flash: address map,
 * busy and latch handling, protection checks, quad pin mode, register read
 * repeat and the discovery table. Assumes a front end that decodes each
 * instruction into one fls_instr_t pulse and asks for each further output
 * byte with rd_byte_req while chip select is low. All inputs except rstn are synchronous.
 */
`include "fls_defines.svh"

// Behaviour
// R1 - 4K sectors, 32K and 64K blocks
// R2 - Blocks are eight or sixteen aligned sectors
// R3 - Decode addresses up to 7FFFFFh
// R4 - Discovery table holds mandatory FF00h header
// R5 - Continuous register read repeats the byte
// R6 - Status byte layout, all bits reset zero
// R7 - Busy bit read-only, set during cycles
// R8 - Latch set/cleared only by its instructions
// R9 - Latch clears when an operation completes
// R10 - Latch low inhibits writes, programs, erases
// R11 - Host issues write enable before writes
// R12 - Program opcodes 02h, 32h, 38h, 62h
// R13 - Erase opcodes D7h, 20h, 52h, D8h, C7h, 60h, 64h
// R14 - Status write 01h, function write 42h
// R15 - Read-status returns current status contents
// R16 - Nonzero protect bits protect their blocks
// R17 - Quad enable bit switches quad function
// R18 - Write-disable bit marks status write-protected
// R19 - Disable bit plus low pin blocks writes
// R20 - Chip erase needs all protect bits zero
// R21 - Quad enable turns protect/hold into data
// R22 - Busy spans cycle, latch falls with busy
// R23 - Gated instruction without latch changes nothing
module fls_status_bank #(
  parameter int unsigned T_SWR_CYC  = `FLS_T_SWR_CYC,
  parameter int unsigned T_PROG_CYC = `FLS_T_PROG_CYC,
  parameter int unsigned T_SER_CYC  = `FLS_T_SER_CYC,
  parameter int unsigned T_BER_CYC  = `FLS_T_BER_CYC,
  parameter int unsigned T_CER_CYC  = `FLS_T_CER_CYC
) (
  input  wire logic               core_clk,
  input  wire logic               rstn,
  input  wire fls_pkg::fls_instr_t instr,
  input  wire logic               cs_n,
  input  wire logic               rd_byte_req,
  input  wire logic               wp_n,
  output logic [7:0]              status_q,
  output logic [7:0]              rd_data_q,
  output logic                    rd_valid_q,
  output logic                    quad_enable_q,
  output logic                    io2_is_data_q,
  output logic                    io3_is_data_q,
  output fls_pkg::fls_op_t        array_op_q,
  output logic                    func_write_q,
  output logic [7:0]              func_data_q,
  output logic                    refused_q
);

  localparam int CW = `FLS_CNT_W;
  // Literals cannot be sliced, so the table constants get names first
  localparam logic [31:0] SFDP_SIG   = `FLS_SFDP_SIG;
  localparam logic [15:0] SFDP_ID    = `FLS_SFDP_ID;
  localparam logic [4:0]  SFDP_BYTES = `FLS_SFDP_BYTES;

  // Non-volatile bits {write disable, quad enable, protect 3..0}
  logic [5:0]          nv_q;
  logic [5:0]          nv_d;
  logic [5:0]          pend_q;
  logic [5:0]          pend_d;
  logic                pend_sr_q;
  logic                pend_sr_d;
  logic                wel_q;
  logic                wel_d;
  fls_pkg::fls_state_t state_q;
  fls_pkg::fls_state_t state_d;
  logic [7:0]          status_d;
  logic                quad_d;
  fls_pkg::fls_op_t    op_d;
  logic                func_d;
  logic [7:0]          fdata_d;
  logic                refuse_d;
  logic                t_start;
  logic [CW-1:0]       t_len;
  logic                t_done;

  // Read side
  fls_pkg::fls_rd_src_t rd_src_q;
  fls_pkg::fls_rd_src_t rd_src_d;
  logic [4:0]           sfdp_ptr_q;
  logic [4:0]           sfdp_ptr_d;
  logic [7:0]           rd_data_d;
  logic                 rd_valid_d;

  logic [3:0] bp;
  logic       busy;
  logic       gated;
  logic       is_chip;
  logic       prot_hit;
  fls_pkg::fls_kind_t kind;
  fls_pkg::fls_map_t  map;

  assign bp   = nv_q[3:0];
  assign busy = (state_q == fls_pkg::FLS_CYCLE);

  // Sector and block numbers are plain slices, so blocks stay aligned  [R1] [R2]
  assign map.sector     = instr.addr[`FLS_ADDR_W-1:`FLS_SECTOR_LSB];   // [R3]
  assign map.half_block = instr.addr[`FLS_ADDR_W-1:`FLS_HALF_LSB];
  assign map.block      = instr.addr[`FLS_ADDR_W-1:`FLS_BLOCK_LSB];

  // Instructions that need the latch, and their array kind  [R12] [R13] [R14]
  always_comb begin
    gated   = 1'b1;
    is_chip = 1'b0;
    kind    = fls_pkg::FLS_K_PROG;
    unique case (instr.opcode)
      `FLS_OP_PROG_C, `FLS_OP_QPROG_A_C, `FLS_OP_QPROG_B_C: kind = fls_pkg::FLS_K_PROG;
      `FLS_OP_IR_PROG_C:                  kind = fls_pkg::FLS_K_IR_PROG;
      `FLS_OP_SECT_A_C, `FLS_OP_SECT_B_C: kind = fls_pkg::FLS_K_SECTOR;
      `FLS_OP_HALF_C:                     kind = fls_pkg::FLS_K_HALF;
      `FLS_OP_BLOCK_C:                    kind = fls_pkg::FLS_K_BLOCK;
      `FLS_OP_CHIP_A_C, `FLS_OP_CHIP_B_C: begin
        kind    = fls_pkg::FLS_K_CHIP;
        is_chip = 1'b1;
      end
      `FLS_OP_IR_ERASE_C:                 kind = fls_pkg::FLS_K_IR_ERASE;
      `FLS_OP_SWR_C, `FLS_OP_FWR_C:       kind = fls_pkg::FLS_K_PROG;
      default:                            gated = 1'b0;
    endcase
  end

  // Top-area protection: zero protects none, 8..15 all, n the top 2^(n-1)
  always_comb begin
    logic [7:0] lim;
    lim      = `FLS_BLOCK_COUNT - (8'h01 << (bp[2:0] - 3'h1));
    prot_hit = 1'b0;
    if (kind == fls_pkg::FLS_K_IR_PROG || kind == fls_pkg::FLS_K_IR_ERASE) begin
      prot_hit = 1'b0;                               // Info rows lie outside the map
    end else if (bp[3]) begin
      prot_hit = 1'b1;                               // [R16]
    end else if (bp != 4'h0) begin
      prot_hit = ({1'b0, map.block} >= lim);         // [R16]
    end
  end

  // Cycle length per kind
  always_comb begin
    unique case (kind)
      fls_pkg::FLS_K_PROG, fls_pkg::FLS_K_IR_PROG: t_len = CW'(T_PROG_CYC);
      fls_pkg::FLS_K_SECTOR, fls_pkg::FLS_K_IR_ERASE: t_len = CW'(T_SER_CYC);
      fls_pkg::FLS_K_HALF, fls_pkg::FLS_K_BLOCK: t_len = CW'(T_BER_CYC);
      fls_pkg::FLS_K_CHIP: t_len = CW'(T_CER_CYC);
      default: t_len = CW'(T_PROG_CYC);              // Unused kind code
    endcase
    if (instr.opcode == `FLS_OP_SWR_C || instr.opcode == `FLS_OP_FWR_C) begin
      t_len = CW'(T_SWR_CYC);
    end
  end

  // Latch, busy and non-volatile bits. Completion is handled before the
  // new instruction, which still sees busy; a gated one is refused in that cycle.
  always_comb begin
    nv_d      = nv_q;
    pend_d    = pend_q;
    pend_sr_d = pend_sr_q;
    wel_d     = wel_q;
    state_d   = state_q;
    op_d      = '0;
    func_d    = 1'b0;
    fdata_d   = func_data_q;
    refuse_d  = 1'b0;
    t_start   = 1'b0;
    if (t_done) begin
      state_d   = fls_pkg::FLS_READY;                // [R7] [R22]
      wel_d     = 1'b0;                              // [R9] [R22]
      pend_sr_d = 1'b0;
      if (pend_sr_q) begin
        nv_d = pend_q;                               // [R14]
      end
    end
    if (instr.valid) begin
      if (instr.opcode == `FLS_OP_WEN_C) begin
        if (!busy) begin
          wel_d = 1'b1;                              // [R8]
        end
      end else if (instr.opcode == `FLS_OP_WDIS_C) begin
        if (!busy) begin
          wel_d = 1'b0;                              // [R8]
        end
      end else if (gated) begin
        if (busy || !wel_q) begin
          refuse_d = 1'b1;                           // [R10] [R23] [R11]
        end else if (instr.opcode == `FLS_OP_SWR_C) begin
          if (nv_q[5] && !wp_n) begin
            refuse_d = 1'b1;                         // [R18] [R19]
          end else begin
            pend_d    = instr.wdata[7:2];            // Latch bits untouched [R8]
            pend_sr_d = 1'b1;
            t_start   = 1'b1;
            state_d   = fls_pkg::FLS_CYCLE;          // [R7]
          end
        end else if (instr.opcode == `FLS_OP_FWR_C) begin
          func_d  = 1'b1;                            // [R14]
          fdata_d = instr.wdata;
          t_start = 1'b1;
          state_d = fls_pkg::FLS_CYCLE;
        end else if (is_chip && bp != 4'h0) begin
          refuse_d = 1'b1;                           // [R20]
        end else if (!is_chip && prot_hit) begin
          refuse_d = 1'b1;                           // [R16]
        end else begin
          op_d.valid = 1'b1;
          op_d.kind  = kind;
          op_d.addr  = instr.addr & `FLS_ADDR_MAX;   // [R3]
          op_d.map   = map;
          t_start    = 1'b1;
          state_d    = fls_pkg::FLS_CYCLE;           // [R7]
        end
      end
    end
    status_d = {nv_d, wel_d, (state_d == fls_pkg::FLS_CYCLE)};  // [R6]
    quad_d   = nv_d[4];                              // [R17]
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      nv_q          <= 6'h00;
      pend_q        <= 6'h00;
      pend_sr_q     <= 1'b0;
      wel_q         <= 1'b0;
      state_q       <= fls_pkg::FLS_READY;
      status_q      <= `FLS_SR_RESET;                // [R6]
      quad_enable_q <= 1'b0;
      io2_is_data_q <= 1'b0;
      io3_is_data_q <= 1'b0;
      array_op_q    <= '0;
      func_write_q  <= 1'b0;
      func_data_q   <= 8'h00;
      refused_q     <= 1'b0;
    end else begin
      nv_q          <= nv_d;
      pend_q        <= pend_d;
      pend_sr_q     <= pend_sr_d;
      wel_q         <= wel_d;
      state_q       <= state_d;
      status_q      <= status_d;
      quad_enable_q <= quad_d;                       // [R17]
      io2_is_data_q <= quad_d;                       // [R21]
      io3_is_data_q <= quad_d;                       // [R21]
      array_op_q    <= op_d;
      func_write_q  <= func_d;
      func_data_q   <= fdata_d;
      refused_q     <= refuse_d;
    end
  end

  fls_cycle_timer #(
    .CNT_W (CW)
  ) u_timer (
    .core_clk (core_clk),
    .rstn     (rstn),
    .start    (t_start),
    .len      (t_len),
    .done     (t_done),
    .running  ()
  );

  // Discovery table: signature, one header with id FF00h, then its table.
  // Unprogrammed locations read as erased bytes.
  function automatic logic [7:0] sfdp_byte(input logic [4:0] a);
    logic [7:0] b;
    b = 8'hFF;
    unique case (a)
      5'h00: b = SFDP_SIG[7:0];
      5'h01: b = SFDP_SIG[15:8];
      5'h02: b = SFDP_SIG[23:16];
      5'h03: b = SFDP_SIG[31:24];
      5'h04: b = 8'h00;                              // Minor revision
      5'h05: b = 8'h01;                              // Major revision
      5'h06: b = 8'h00;                              // One header only
      5'h07: b = 8'hFF;
      5'h08: b = SFDP_ID[7:0];                       // [R4]
      5'h09: b = 8'h00;
      5'h0A: b = 8'h01;
      5'h0B: b = 8'h01;                              // Table length, dwords
      5'h0C: b = {3'b000, SFDP_BYTES};
      5'h0D: b = 8'h00;
      5'h0E: b = 8'h00;
      5'h0F: b = SFDP_ID[15:8];                      // [R4]
      5'h10: b = 8'hE5;                              // Basic table: 4K erase
      5'h11: b = 8'h20;
      5'h12: b = 8'hF1;
      5'h13: b = 8'hFF;
      default: b = 8'hFF;
    endcase
    return b;
  endfunction

  // Register read source follows the frame; the status byte is sent again
  // on every further request so a polling host sees busy fall live.
  always_comb begin
    rd_src_d   = rd_src_q;
    sfdp_ptr_d = sfdp_ptr_q;
    rd_data_d  = rd_data_q;
    rd_valid_d = 1'b0;
    if (cs_n) begin
      rd_src_d = fls_pkg::FLS_RD_NONE;               // Frame end stops the repeat [R5]
    end
    if (instr.valid && instr.opcode == `FLS_OP_SRD_C) begin
      rd_src_d   = fls_pkg::FLS_RD_STATUS;
      rd_data_d  = status_q;                         // [R15]
      rd_valid_d = 1'b1;
    end else if (instr.valid && instr.opcode == `FLS_OP_SFDP_C) begin
      rd_src_d   = fls_pkg::FLS_RD_SFDP;
      sfdp_ptr_d = instr.addr[4:0] + 5'h01;
      rd_data_d  = sfdp_byte(instr.addr[4:0]);       // [R4]
      rd_valid_d = 1'b1;
    end else if (rd_byte_req && !cs_n) begin
      unique case (rd_src_q)
        fls_pkg::FLS_RD_STATUS: begin
          rd_data_d  = status_q;                     // [R5] [R15]
          rd_valid_d = 1'b1;
        end
        fls_pkg::FLS_RD_SFDP: begin
          rd_data_d  = sfdp_byte(sfdp_ptr_q);
          sfdp_ptr_d = sfdp_ptr_q + 5'h01;
          rd_valid_d = 1'b1;
        end
        default: rd_valid_d = 1'b0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rd_src_q   <= fls_pkg::FLS_RD_NONE;
      sfdp_ptr_q <= 5'h00;
      rd_data_q  <= 8'h00;
      rd_valid_q <= 1'b0;
    end else begin
      rd_src_q   <= rd_src_d;
      sfdp_ptr_q <= sfdp_ptr_d;
      rd_data_q  <= rd_data_d;
      rd_valid_q <= rd_valid_d;
    end
  end

endmodule // fls_status_bank

/* test/fsw_host.sv */
/*
 * Host side model: drives decoded instructions, select, read requests and
 * the protect pin of the status bank. Assumes every task is entered just
 * after a rising core_clk edge and returns just after one.
 */
module fsw_host (
  output fls_pkg::fls_instr_t instr,
  output logic                cs_n,
  output logic                rd_byte_req,
  output logic                wp_n,
  input  wire logic           core_clk
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle pins: deselected, protect pin released high
  initial begin
    instr = '0;
    cs_n = 1'b1;
    rd_byte_req = 1'b0;
    wp_n = 1'b1;
  end

  // One instruction pulse; fields are inverted once released so stale values never pass
  task automatic send(input logic [7:0] op, input logic [22:0] addr, input logic [7:0] wd);
    @(posedge core_clk);
    #10;
    instr = '{valid: 1'b1, opcode: op, addr: addr, wdata: wd};
    @(posedge core_clk);
    #10;
    instr = '{valid: 1'b0, opcode: ~op, addr: ~addr, wdata: ~wd};
  endtask

  // One more read byte clocked by the host
  task automatic req();
    @(posedge core_clk);
    #10;
    rd_byte_req = 1'b1;
    @(posedge core_clk);
    #10;
    rd_byte_req = 1'b0;
  endtask

  // Select and protect pin levels, changed between instructions only
  task automatic pins(input logic cs, input logic wp);
    @(posedge core_clk);
    #10;
    cs_n = cs;
    wp_n = wp;
  endtask
endmodule // fsw_host

/* test/fsw_checker.sv */
/*
 * Concurrent checks on the ports of the status bank.
 * Assumes a single core_clk domain with asynchronous active-low rstn.
 */
module fsw_checker (
  input wire logic                core_clk,
  input wire logic                rstn,
  input wire fls_pkg::fls_instr_t instr,
  input wire logic                cs_n,
  input wire logic                rd_byte_req,
  input wire logic                wp_n,
  input wire logic [7:0]          status_q,
  input wire logic [7:0]          rd_data_q,
  input wire logic                rd_valid_q,
  input wire logic                quad_enable_q,
  input wire logic                io2_is_data_q,
  input wire logic                io3_is_data_q,
  input wire fls_pkg::fls_op_t    array_op_q,
  input wire logic                func_write_q,
  input wire logic [7:0]          func_data_q,
  input wire logic                refused_q
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // Opcodes that need the latch
  logic gated;
  assign gated = instr.valid && (instr.opcode inside {8'h01, 8'h42, 8'h02, 8'h32, 8'h38,
                 8'h62, 8'hD7, 8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60, 8'h64});

  a_quad_pin_mode: assert property (io2_is_data_q == status_q[6] && io3_is_data_q == status_q[6]
    && quad_enable_q == status_q[6]) else $error("quad pin mode differs from status");
  a_latch_set_write_enable_cmd: assert property (instr.valid && instr.opcode == 8'h06 && !status_q[0]
    |=> status_q[1]) else $error("write enable did not set latch");
  a_latch_clr_write_disable_cmd: assert property (instr.valid && instr.opcode == 8'h04 && !status_q[0]
    |=> !status_q[1]) else $error("write disable did not clear latch");
  a_gated_no_latch: assert property (gated && !status_q[1] |=> refused_q && $stable(status_q)
    && !array_op_q.valid) else $error("gated instruction ran without latch");
  a_chip_erase_bp: assert property (instr.valid && instr.opcode inside {8'hC7, 8'h60}
    && status_q[5:2] != 4'h0 |=> refused_q && !array_op_q.valid)
    else $error("chip erase ran with protect bits set");
  a_status_lock: assert property (instr.valid && instr.opcode == 8'h01 && status_q[7] && !wp_n
    |=> refused_q) else $error("locked status write accepted");
  a_busy_drop_latch: assert property ($fell(status_q[0]) |-> $fell(status_q[1]))
    else $error("latch did not fall with busy");
  a_busy_on_launch: assert property (array_op_q.valid |-> status_q[0] ##1 status_q[0])
    else $error("busy not raised by operation");
  a_read_answer: assert property (instr.valid && instr.opcode == 8'h05
    |=> rd_valid_q && rd_data_q == $past(status_q)) else $error("status read wrong");
  a_read_deselect: assert property (rd_byte_req && cs_n && !instr.valid |=> !rd_valid_q)
    else $error("read byte given while deselected");

  c_launch: cover property (array_op_q.valid);
  c_refused: cover property (refused_q);
  c_read: cover property (rd_valid_q ##[2:5] rd_valid_q);
endmodule // fsw_checker

bind fls_status_bank fsw_checker chk_u (.core_clk, .rstn, .instr, .cs_n, .rd_byte_req, .wp_n,
  .status_q, .rd_data_q, .rd_valid_q, .quad_enable_q, .io2_is_data_q, .io3_is_data_q,
  .array_op_q, .func_write_q, .func_data_q, .refused_q);

/* test/tb.sv */
/*
 * Self-checking bench for the status bank: host model tasks in sequence.
 * Assumes short internal cycle lengths set below.
 */
`include "fls_defines.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                core_clk;
  logic                rstn;
  fls_pkg::fls_instr_t instr;
  logic                cs_n;
  logic                rd_byte_req;
  logic                wp_n;
  logic [7:0]          status_q;
  logic [7:0]          rd_data_q;
  logic                rd_valid_q;
  logic                quad_enable_q;
  logic                io2_is_data_q;
  logic                io3_is_data_q;
  fls_pkg::fls_op_t    array_op_q;
  logic                func_write_q;
  logic [7:0]          func_data_q;
  logic                refused_q;
  int                  error_cnt = 0;
  int                  compares = 0;
  int                  cyc = 0;
  int                  n;
  // Gated opcodes, their operation kind and expected cycle length (0: not timed here)
  logic [7:0]          ops [11] = '{8'h02, 8'h32, 8'h38, 8'h62, 8'hD7, 8'h20, 8'h52, 8'hD8,
                                    8'hC7, 8'h60, 8'h64};
  logic [2:0]          kinds [11] = '{0, 0, 0, 1, 2, 2, 3, 4, 5, 5, 6};
  int                  lens [11] = '{3, 3, 3, 0, 4, 4, 5, 5, 6, 6, 0};

  fsw_host host_u (.instr(instr), .cs_n(cs_n), .rd_byte_req(rd_byte_req), .wp_n(wp_n),
    .core_clk(core_clk));

  fls_status_bank #(.T_SWR_CYC(2), .T_PROG_CYC(3), .T_SER_CYC(4), .T_BER_CYC(5),
    .T_CER_CYC(6)) dut_u (.core_clk(core_clk), .rstn(rstn), .instr(instr), .cs_n(cs_n),
    .rd_byte_req(rd_byte_req), .wp_n(wp_n), .status_q(status_q), .rd_data_q(rd_data_q),
    .rd_valid_q(rd_valid_q), .quad_enable_q(quad_enable_q), .io2_is_data_q(io2_is_data_q),
    .io3_is_data_q(io3_is_data_q), .array_op_q(array_op_q), .func_write_q(func_write_q),
    .func_data_q(func_data_q), .refused_q(refused_q));

  // 10 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // Hang guard, generous against the roughly 180 cycles the sequence needs
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      final_report();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Counts edges until busy clears, bounded
  task automatic wait_ready(output int cnt);
    cnt = 0;
    while (status_q[0] !== 1'b0 && cnt < 1000) begin
      @(posedge core_clk);
      #10;
      cnt++;
    end
  endtask

  task automatic final_report();
    if (error_cnt == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    rstn = 1'b0;
    repeat (10) @(posedge core_clk);
    #10;
    rstn = 1'b1;
    check("reset status", status_q, 8'h00);
    host_u.send(8'h02, 23'h00_0000, 8'h00);
    check("no latch refused", refused_q, 1);
    check("no latch no op", array_op_q.valid, 0);
    for (int i = 0; i < 11; i++) begin
      host_u.send(8'h06, 23'h00_0000, 8'h00);
      check("latch set", status_q, 8'h02);
      host_u.send(ops[i], 23'h7F_F000, 8'h00);
      check("op launched", array_op_q.valid, 1);
      check("op kind", array_op_q.kind, kinds[i]);
      check("op map", array_op_q.map, {11'h7FF, 8'hFF, 7'h7F});
      check("op addr", array_op_q.addr, 23'h7F_F000);
      check("busy and latch", status_q[1:0], 2'b11);
      wait_ready(n);
      if (lens[i] > 0) check("busy length", n, lens[i] + 1);
      check("latch auto clear", status_q, 8'h00);
    end
    host_u.send(8'h06, 23'h00_0000, 8'h00);
    host_u.send(8'h01, 23'h00_0000, 8'h47);
    wait_ready(n);
    check("status write length", n, 3);
    check("status written", status_q, 8'h44);
    check("quad pins", {quad_enable_q, io2_is_data_q, io3_is_data_q}, 3'b111);
    host_u.pins(1'b0, 1'b1);
    host_u.send(8'h05, 23'h00_0000, 8'h00);
    check("status read", {rd_valid_q, rd_data_q}, 9'h144);
    repeat (2) begin
      host_u.req();
      check("status repeat", {rd_valid_q, rd_data_q}, 9'h144);
    end
    host_u.pins(1'b1, 1'b1);
    host_u.req();
    check("read ended", rd_valid_q, 0);
    host_u.send(8'h06, 23'h00_0000, 8'h00);
    host_u.send(8'hC7, 23'h00_0000, 8'h00);
    check("chip erase blocked", refused_q, 1);
    host_u.send(8'hD8, 23'h7F_0000, 8'h00);
    check("protected block", refused_q, 1);
    host_u.send(8'hD8, 23'h00_0000, 8'h00);
    check("open block", array_op_q.valid, 1);
    wait_ready(n);
    host_u.send(8'h06, 23'h00_0000, 8'h00);
    host_u.send(8'h01, 23'h00_0000, 8'h80);
    wait_ready(n);
    check("disable bit set", status_q, 8'h80);
    host_u.pins(1'b1, 1'b0);
    host_u.send(8'h06, 23'h00_0000, 8'h00);
    host_u.send(8'h01, 23'h00_0000, 8'h00);
    check("locked write refused", {refused_q, status_q}, 9'h182);
    host_u.pins(1'b1, 1'b1);
    host_u.send(8'h01, 23'h00_0000, 8'h00);
    wait_ready(n);
    check("unlocked write", status_q, 8'h00);
    host_u.send(8'h06, 23'h00_0000, 8'h00);
    host_u.send(8'h04, 23'h00_0000, 8'h00);
    check("latch cleared", status_q, 8'h00);
    host_u.send(8'h06, 23'h00_0000, 8'h00);
    host_u.send(8'h42, 23'h00_0000, 8'hA5);
    check("function write", {func_write_q, func_data_q}, 9'h1A5);
    wait_ready(n);
    host_u.pins(1'b0, 1'b1);
    host_u.send(8'h5A, 23'h00_0000, 8'h00);
    check("discovery byte", rd_data_q, `FLS_SFDP_SIG & 32'h0000_00FF);
    for (int i = 1; i < 4; i++) begin
      host_u.req();
      check("discovery byte", rd_data_q, (`FLS_SFDP_SIG >> (8 * i)) & 32'h0000_00FF);
    end
    host_u.pins(1'b1, 1'b1);
    final_report();
  end
endmodule // tb
